// ---- core/erp_pkg.sv ----
package erp_pkg;

    // Bus geometry: printed offsets are word indexes, byte address = index * 4
    localparam int unsigned ERP_ADDR_W = 10;
    localparam int unsigned ERP_DATA_W = 32;
    localparam int unsigned ERP_CHANNELS = 2;

    // Register indexes
    localparam logic [7:0] ERP_IDX_B_EXTENSION = 8'hE6;
    localparam logic [7:0] ERP_IDX_B_DUTY_DATA = 8'hE7;
    localparam logic [7:0] ERP_IDX_B_CONTROL = 8'hE8;
    localparam logic [7:0] ERP_IDX_A_EXTENSION = 8'hF1;
    localparam logic [7:0] ERP_IDX_A_DUTY_DATA = 8'hF2;
    localparam logic [7:0] ERP_IDX_A_CONTROL = 8'hF3;
    localparam logic [7:0] ERP_IDX_IRQ_STATUS = 8'hE0;
    localparam logic [7:0] ERP_IDX_IRQ_MASK = 8'hE1;

    // Control register fields
    localparam int unsigned ERP_CTL_CLK_HI = 7;
    localparam int unsigned ERP_CTL_CLK_LO = 6;
    localparam int unsigned ERP_CTL_RELOAD = 5;
    localparam int unsigned ERP_CTL_CLEAR = 3;
    localparam int unsigned ERP_CTL_START = 2;
    localparam int unsigned ERP_CTL_OVF_IE = 1;

    // Extension register fields
    localparam int unsigned ERP_EXT_DUTY_HI = 7;
    localparam int unsigned ERP_EXT_DUTY_LO = 2;
    localparam int unsigned ERP_EXT_MODE_HI = 1;
    localparam int unsigned ERP_EXT_MODE_LO = 0;

    // Resolution codes; bit 0 clear means 6-bit base + 6-bit extension
    localparam logic [1:0] ERP_MODE_6P2 = 2'h1;
    localparam logic [1:0] ERP_MODE_8P6 = 2'h3;

    // Counter clock selection codes and prescaler terminal counts
    localparam logic [1:0] ERP_SEL_DIV64 = 2'h0;
    localparam logic [1:0] ERP_SEL_DIV8 = 2'h1;
    localparam logic [1:0] ERP_SEL_DIV2 = 2'h2;
    localparam logic [1:0] ERP_SEL_DIV1 = 2'h3;
    localparam logic [5:0] ERP_PRE_MAX_DIV64 = 6'h3F;
    localparam logic [5:0] ERP_PRE_MAX_DIV8 = 6'h07;
    localparam logic [5:0] ERP_PRE_MAX_DIV2 = 6'h01;
    localparam logic [5:0] ERP_PRE_MAX_DIV1 = 6'h00;

    // Counter limits
    localparam logic [7:0] ERP_BASE_MAX_6 = 8'h3F;
    localparam logic [7:0] ERP_BASE_MAX_8 = 8'hFF;
    localparam logic [5:0] ERP_EXT_MAX_6 = 6'h3F;
    localparam logic [5:0] ERP_EXT_MAX_2 = 6'h03;

    // Reset values
    localparam logic [7:0] ERP_CTL_RST = 8'h00;
    localparam logic [7:0] ERP_EXT_RST = 8'h00;
    localparam logic [7:0] ERP_DATA_RST = 8'h00;
    localparam logic [1:0] ERP_IRQ_RST = 2'h0;

    // Per-modulator configuration carried into a channel
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] ext;
        logic [7:0] data;
        logic clear;
    } erp_cfg_t;

endpackage

// ---- core/erp_top.sv ----
`timescale 1ns/1ps
// Function
// - Output goes low when base counter equals the base reference value.
// - Base counter overflow drives output high when reference value is nonzero.
// - Matching extension cycles get high time lengthened by one counter clock.
// - Six-bit mode: top extension bit stretches all odd cycles of 64.
// - Lower extension bits stretch 2 mod 4, 4 mod 8 ... down to cycle 32.
// - Eight-bit base mode uses the same pattern; 04h stretches cycle 32 only.
// - Two-bit mode: 00 none, 01 cycle 2, 10 cycles 1,3, 11 cycles 1-3.
// - Counter clock derived from pclk using control bits 7 and 6.
// - Control selects when newly written duty data are reloaded.
// - Upper counter overflow raises an interrupt request when enabled.
// - Reset clears all control bits, stopping the modulator.
// - Extension register holds duty bits 7-2 and resolution in bits 1-0.
// - Extension register resets to 00h, no stretching.
// - Resolution x0 six plus six, 01 six plus two, 11 eight plus six.
// - Counter clock choices are pclk divided by 64, 8, 2 or 1.
// - Bit 2 starts, clearing it pauses holding count; bit 3 clears counter.
// - Lower base counter compared with the base data register value.

module erp_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire erp_pkg::erp_cfg_t cfg,
    output logic pwm_out,
    output logic frame_ovf
);

    logic [5:0] pre_q, pre_d;
    logic [7:0] base_q, base_d;
    logic [5:0] ext_q, ext_d;
    logic out_q, out_d;
    logic [7:0] act_data_q, act_data_d;
    logic [5:0] act_ext_q, act_ext_d;
    logic [1:0] mode;
    logic two_bit, wide_base, start, tick, base_wrap, ext_wrap, stretch, reload;
    logic [5:0] pre_max, ext_max, cyc_num;
    logic [7:0] base_max, base_val;
    logic [8:0] cmp;

    // Mode, prescaler and stretch decode
    always_comb begin
        mode = cfg.ext[erp_pkg::ERP_EXT_MODE_HI:erp_pkg::ERP_EXT_MODE_LO];
        two_bit = (mode == erp_pkg::ERP_MODE_6P2);
        wide_base = (mode == erp_pkg::ERP_MODE_8P6);
        start = cfg.ctl[erp_pkg::ERP_CTL_START];
        unique case (cfg.ctl[erp_pkg::ERP_CTL_CLK_HI:erp_pkg::ERP_CTL_CLK_LO])
            erp_pkg::ERP_SEL_DIV64: pre_max = erp_pkg::ERP_PRE_MAX_DIV64;
            erp_pkg::ERP_SEL_DIV8: pre_max = erp_pkg::ERP_PRE_MAX_DIV8;
            erp_pkg::ERP_SEL_DIV2: pre_max = erp_pkg::ERP_PRE_MAX_DIV2;
            erp_pkg::ERP_SEL_DIV1: pre_max = erp_pkg::ERP_PRE_MAX_DIV1;
        endcase
        // >= so a smaller divisor chosen mid-count takes effect at once
        tick = start && (pre_q >= pre_max);
        base_max = wide_base ? erp_pkg::ERP_BASE_MAX_8 : erp_pkg::ERP_BASE_MAX_6;
        ext_max = two_bit ? erp_pkg::ERP_EXT_MAX_2 : erp_pkg::ERP_EXT_MAX_6;
        base_wrap = tick && (base_q == base_max);
        ext_wrap = base_wrap && (ext_q == ext_max);
        base_val = wide_base ? act_data_q : {2'h0, act_data_q[5:0]};
        // Cycles are numbered from 1; cycle 64 wraps to 0, two-bit cycle 4 stays 4
        cyc_num = ext_q + 6'h01;
        stretch = 1'b0;
        for (int j = 0; j < 6; j++) begin
            // Bit 7-j stretches cycles n with n mod 2^(j+1) == 2^j
            if (act_ext_q[5 - j] && (!two_bit || j < 2) &&
                ((cyc_num & 6'((2 << j) - 1)) == 6'(1 << j))) begin
                stretch = 1'b1;
            end
        end
        cmp = {1'b0, base_val} + {8'h00, stretch};
        frame_ovf = ext_wrap;
        reload = cfg.ctl[erp_pkg::ERP_CTL_RELOAD] ? ext_wrap : base_wrap;
    end

    // Counters, output and duty reload
    always_comb begin
        pre_d = pre_q;
        base_d = base_q;
        ext_d = ext_q;
        out_d = out_q;
        act_data_d = act_data_q;
        act_ext_d = act_ext_q;
        // Stopped counter takes new duty at once so the restart is clean
        if (!start || reload || cfg.clear) begin
            act_data_d = cfg.data;
            act_ext_d = cfg.ext[erp_pkg::ERP_EXT_DUTY_HI:erp_pkg::ERP_EXT_DUTY_LO];
        end
        if (cfg.clear) begin
            pre_d = 6'h00;
            base_d = 8'h00;
            ext_d = 6'h00;
            out_d = 1'b0;
        end else if (start) begin
            pre_d = tick ? 6'h00 : pre_q + 6'h01;
            if (tick) begin
                base_d = base_wrap ? 8'h00 : base_q + 8'h01;
                if (base_wrap) begin
                    ext_d = ext_wrap ? 6'h00 : ext_q + 6'h01;
                end
                if ({1'b0, base_d} == cmp) begin
                    out_d = 1'b0;
                end else if (base_wrap && base_val != 8'h00) begin
                    out_d = 1'b1;
                end
            end
        end
    end

    // Channel state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 6'h00;
            base_q <= 8'h00;
            ext_q <= 6'h00;
            out_q <= 1'b0;
            act_data_q <= erp_pkg::ERP_DATA_RST;
            act_ext_q <= 6'h00;
        end else begin
            pre_q <= pre_d;
            base_q <= base_d;
            ext_q <= ext_d;
            out_q <= out_d;
            act_data_q <= act_data_d;
            act_ext_q <= act_ext_d;
        end
    end

    assign pwm_out = out_q;

    a_low_on_match: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !cfg.clear && {1'b0, base_d} == cmp) |=> !pwm_out)
        else $error("output not low after base match");

    a_high_on_ovf: assert property (@(posedge pclk) disable iff (!presetn)
        (base_wrap && !cfg.clear && base_val != 8'h00 && cmp != 9'h000) |=> pwm_out)
        else $error("output not high after base overflow");

    a_zero_low: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pwm_out) |-> $past(base_val) != 8'h00)
        else $error("output rose with zero reference");

    a_odd_stretch: assert property (@(posedge pclk) disable iff (!presetn)
        (!mode[0] && act_ext_q[5] && cyc_num[0]) |-> stretch)
        else $error("odd cycle not stretched");

    a_cycle32_only: assert property (@(posedge pclk) disable iff (!presetn)
        (wide_base && act_ext_q == 6'h01) |-> (stretch == (cyc_num == 6'h20)))
        else $error("04h pattern wrong");

    a_two_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (two_bit && act_ext_q[5:4] == 2'h1) |-> (stretch == (cyc_num[1:0] == 2'h2)))
        else $error("two-bit code 01 pattern wrong");

    a_div8_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && start && cfg.ctl[7:6] == erp_pkg::ERP_SEL_DIV8 && !cfg.clear)
        |=> (!tick || cfg.ctl[7:6] != erp_pkg::ERP_SEL_DIV8 || cfg.clear) [*7])
        else $error("divide by 8 tick spacing wrong");

    a_reload_frame: assert property (@(posedge pclk) disable iff (!presetn)
        (start && cfg.ctl[erp_pkg::ERP_CTL_RELOAD] && !ext_wrap && !cfg.clear)
        |=> $stable(act_data_q))
        else $error("duty data reloaded inside a frame");

    a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (!start && !cfg.clear) |=> ($stable(base_q) && $stable(ext_q)))
        else $error("stopped counter moved");

    a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.clear |=> (base_q == 8'h00 && ext_q == 6'h00 && !pwm_out))
        else $error("clear did not zero counter");

    a_ext_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_wrap && !cfg.clear) |=> (ext_q == 6'h00 && base_q == 8'h00))
        else $error("extension counter did not wrap");

endmodule // erp_channel

module erp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [erp_pkg::ERP_ADDR_W-1:0] paddr,
    input wire logic [erp_pkg::ERP_DATA_W-1:0] pwdata,
    output logic pready,
    output logic [erp_pkg::ERP_DATA_W-1:0] prdata,
    output logic pslverr,
    output logic pwm_a_out,
    output logic pwm_b_out,
    output logic irq
);

    logic [1:0][7:0] ctl_q, ctl_d;
    logic [1:0][7:0] ext_q, ext_d;
    logic [1:0][7:0] data_q, data_d;
    logic [1:0] status_q, status_d;
    logic [1:0] mask_q, mask_d;
    logic [erp_pkg::ERP_DATA_W-1:0] rdata_q, rdata_d;
    logic slverr_q, slverr_d;
    logic [1:0] ovf, clr_pulse;
    logic setup, wr_en, hit;
    logic [7:0] idx, rbyte, wbyte;
    erp_pkg::erp_cfg_t cfg_a, cfg_b;

    // Address decode and read mux, sampled in the setup cycle
    always_comb begin
        idx = paddr[9:2];
        setup = psel && !penable;
        wr_en = psel && penable && pwrite;
        wbyte = pwdata[7:0];
        hit = 1'b1;
        rbyte = 8'h00;
        unique case (idx)
            erp_pkg::ERP_IDX_A_CONTROL: rbyte = ctl_q[0];
            erp_pkg::ERP_IDX_A_EXTENSION: rbyte = ext_q[0];
            erp_pkg::ERP_IDX_A_DUTY_DATA: rbyte = data_q[0];
            erp_pkg::ERP_IDX_B_CONTROL: rbyte = ctl_q[1];
            erp_pkg::ERP_IDX_B_EXTENSION: rbyte = ext_q[1];
            erp_pkg::ERP_IDX_B_DUTY_DATA: rbyte = data_q[1];
            erp_pkg::ERP_IDX_IRQ_STATUS: rbyte = {6'h00, status_q};
            erp_pkg::ERP_IDX_IRQ_MASK: rbyte = {6'h00, mask_q};
            default: hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
        rdata_d = setup ? {24'h000000, hit ? rbyte : 8'h00} : rdata_q;
        slverr_d = setup && !hit;
    end

    // Register writes, clear strobes and sticky overflow flags
    always_comb begin
        ctl_d = ctl_q;
        ext_d = ext_q;
        data_d = data_q;
        mask_d = mask_q;
        clr_pulse = 2'h0;
        status_d = status_q;
        if (wr_en && hit) begin
            unique case (idx)
                erp_pkg::ERP_IDX_A_CONTROL: begin
                    // Clear bit is a strobe and never stored
                    ctl_d[0] = wbyte & ~(8'h01 << erp_pkg::ERP_CTL_CLEAR);
                    clr_pulse[0] = wbyte[erp_pkg::ERP_CTL_CLEAR];
                end
                erp_pkg::ERP_IDX_B_CONTROL: begin
                    ctl_d[1] = wbyte & ~(8'h01 << erp_pkg::ERP_CTL_CLEAR);
                    clr_pulse[1] = wbyte[erp_pkg::ERP_CTL_CLEAR];
                end
                erp_pkg::ERP_IDX_A_EXTENSION: ext_d[0] = wbyte;
                erp_pkg::ERP_IDX_B_EXTENSION: ext_d[1] = wbyte;
                erp_pkg::ERP_IDX_A_DUTY_DATA: data_d[0] = wbyte;
                erp_pkg::ERP_IDX_B_DUTY_DATA: data_d[1] = wbyte;
                erp_pkg::ERP_IDX_IRQ_STATUS: status_d = status_q & ~wbyte[1:0];
                erp_pkg::ERP_IDX_IRQ_MASK: mask_d = wbyte[1:0];
                default: ;
            endcase
        end
        // A new overflow wins over a write-one clear in the same cycle
        for (int c = 0; c < 2; c++) begin
            if (ovf[c] && ctl_q[c][erp_pkg::ERP_CTL_OVF_IE]) begin
                status_d[c] = 1'b1;
            end
        end
    end

    // Register file and bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= {2{erp_pkg::ERP_CTL_RST}};
            ext_q <= {2{erp_pkg::ERP_EXT_RST}};
            data_q <= {2{erp_pkg::ERP_DATA_RST}};
            status_q <= erp_pkg::ERP_IRQ_RST;
            mask_q <= erp_pkg::ERP_IRQ_RST;
            rdata_q <= '0;
            slverr_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            ext_q <= ext_d;
            data_q <= data_d;
            status_q <= status_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // Channel configuration bundles
    always_comb begin
        cfg_a = '{ctl: ctl_q[0], ext: ext_q[0], data: data_q[0], clear: clr_pulse[0]};
        cfg_b = '{ctl: ctl_q[1], ext: ext_q[1], data: data_q[1], clear: clr_pulse[1]};
    end

    erp_channel u_modulator_a (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_a),
        .pwm_out(pwm_a_out),
        .frame_ovf(ovf[0])
    );

    erp_channel u_modulator_b (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_b),
        .pwm_out(pwm_b_out),
        .frame_ovf(ovf[1])
    );

    // Zero wait states: every access phase completes at once
    assign pready = psel && penable;
    assign prdata = rdata_q;
    assign pslverr = slverr_q;
    assign irq = |(status_q & mask_q);

    a_ovf_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (ovf[0] && ctl_q[0][erp_pkg::ERP_CTL_OVF_IE]) |=> status_q[0] ##0 $past(ovf[0]))
        else $error("overflow did not set status");

    a_ovf_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        (!status_q[1] && !(ovf[1] && ctl_q[1][erp_pkg::ERP_CTL_OVF_IE])) |=> !status_q[1])
        else $error("status set without enabled overflow");

endmodule // erp_top

// ---- tb/tb_erp_top.sv ----
`timescale 1ns/1ps
module tb_erp_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic pwm_a_out;
    logic pwm_b_out;
    logic irq;
    int num_errors = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h047D1F09;
    logic [7:0] idxs [8];
    logic v;
    int k;

    // Free-running 200 MHz clock
    always #2.5 pclk = ~pclk;

    erp_top i_erp_top (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .pwm_a_out(pwm_a_out),
        .pwm_b_out(pwm_b_out),
        .irq(irq)
    );

    // Repeatable pseudo-random source
    function logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
        return seed;
    endfunction

    // Word index to byte address
    function automatic logic [9:0] ad(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

    // High pclk count over one extension frame; totals are alignment-free
    function automatic int exp_high(input logic [1:0] m, input int dv, input logic [7:0] d,
                                    input logic [7:0] e);
        int nb;
        int dd;
        int st;
        nb = (m == 2'h1) ? 4 : 64;
        dd = (m == 2'h3) ? d : d[5:0];
        st = (m == 2'h1) ? e[7:6] : e[7:2];
        if (dd == 0) return 0;
        return dv * (nb * dd + st);
    endfunction

    task complete_run;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data compared only on reads
    task acc(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [31:0] ev,
             input logic ee);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            complete_run();
        end
        if (!w) chk(prdata, ev);
        chk({31'h0, pslverr}, {31'h0, ee});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Configure both channels, let them settle, count high time over one frame
    task run_case(input logic [1:0] m, input logic [1:0] sel, input logic [7:0] da,
                  input logic [7:0] ea, input logic [7:0] db, input logic [7:0] eb);
        int dv;
        int win;
        int ha;
        int hb;
        dv = (sel == 2'h0) ? 64 : (sel == 2'h1) ? 8 : (sel == 2'h2) ? 2 : 1;
        win = dv * ((m == 2'h3) ? 256 : 64) * ((m == 2'h1) ? 4 : 64);
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_EXTENSION), {24'h0, ea[7:2], m}, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_DUTY_DATA), {24'h0, da}, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_B_EXTENSION), {24'h0, eb[7:2], m}, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_B_DUTY_DATA), {24'h0, db}, 0, 1'b0);
        // Two-bit cases reload once per frame, the others on every base overflow
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_CONTROL), {24'h0, sel, 1'(m == 2'h1), 5'h0C}, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_B_CONTROL), {24'h0, sel, 1'(m == 2'h1), 5'h0C}, 0, 1'b0);
        repeat (2 * win / ((m == 2'h1) ? 2 : 32)) @(posedge pclk);
        ha = 0;
        hb = 0;
        repeat (win) begin
            @(negedge pclk);
            ha += (pwm_a_out === 1'b1);
            hb += (pwm_b_out === 1'b1);
        end
        chk(ha, exp_high(m, dv, da, ea));
        chk(hb, exp_high(m, dv, db, eb));
        $display("test pwm mode %0d sel %0d done", m, sel);
    endtask

    initial begin
        idxs = '{erp_pkg::ERP_IDX_A_EXTENSION, erp_pkg::ERP_IDX_A_DUTY_DATA,
                 erp_pkg::ERP_IDX_A_CONTROL, erp_pkg::ERP_IDX_B_EXTENSION,
                 erp_pkg::ERP_IDX_B_DUTY_DATA, erp_pkg::ERP_IDX_B_CONTROL,
                 erp_pkg::ERP_IDX_IRQ_STATUS, erp_pkg::ERP_IDX_IRQ_MASK};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then refused accesses
        foreach (idxs[i]) acc(1'b0, ad(idxs[i]), 0, 32'h0, 1'b0);
        acc(1'b0, ad(8'h10), 0, 32'h0, 1'b1);
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_DUTY_DATA) | 10'h001, 32'hFF, 0, 1'b1);
        acc(1'b0, ad(erp_pkg::ERP_IDX_A_DUTY_DATA), 0, 32'h0, 1'b0);
        // Random data with junk in the upper bits, read back as one byte
        repeat (4) begin
            pwdata <= pwdata;
            v = 1'b0;
            k = rnd();
            acc(1'b1, ad(erp_pkg::ERP_IDX_B_EXTENSION), k, 0, 1'b0);
            acc(1'b0, ad(erp_pkg::ERP_IDX_B_EXTENSION), 0, k & 32'hFF, 1'b0);
        end
        $display("test registers done");
        run_case(2'h0, 2'h3, 8'(rnd() % 62 + 1), 8'(rnd()), 8'(rnd() % 62 + 1), 8'h80);
        run_case(2'h2, 2'h3, 8'(rnd() % 62 + 1), 8'h04, 8'(rnd() % 62 + 1), 8'hFC);
        run_case(2'h3, 2'h3, 8'(rnd() % 254 + 1), 8'h04, 8'(rnd() % 254 + 1), 8'(rnd()));
        for (int s = 0; s < 4; s++) begin
            run_case(2'h1, 2'(s), 8'(rnd() % 62 + 1), {2'(s), 6'h0},
                     8'(rnd() % 62 + 1), {2'(~s), 6'h0});
        end
        run_case(2'h0, 2'h3, 8'h00, 8'hFC, 8'(rnd() % 62 + 1), 8'h00);
        // Stop while high: output and count freeze; clear drops the output
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_DUTY_DATA), 32'h3E, 0, 1'b0);
        k = 0;
        while (pwm_a_out !== 1'b1 && k < 500) begin
            @(negedge pclk);
            k++;
        end
        chk(pwm_a_out, 1'b1);
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_CONTROL), 32'hC0, 0, 1'b0);
        @(negedge pclk);
        v = pwm_a_out;
        repeat (100) @(posedge pclk);
        chk(pwm_a_out, v);
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_CONTROL), 32'hC8, 0, 1'b0);
        repeat (3) @(negedge pclk);
        chk(pwm_a_out, 1'b0);
        acc(1'b0, ad(erp_pkg::ERP_IDX_A_CONTROL), 0, 32'hC0, 1'b0);
        $display("test stop and clear done");
        // Frame overflow interrupt: A enabled, B not; then masked and cleared
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_EXTENSION), 32'h01, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_B_EXTENSION), 32'h01, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_IRQ_MASK), 32'h3, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_CONTROL), 32'hCE, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_B_CONTROL), 32'hCC, 0, 1'b0);
        k = 0;
        while (irq !== 1'b1 && k < 1000) begin
            @(negedge pclk);
            k++;
        end
        chk(irq, 1'b1);
        acc(1'b0, ad(erp_pkg::ERP_IDX_IRQ_STATUS), 0, 32'h1, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_IRQ_MASK), 32'h2, 0, 1'b0);
        @(negedge pclk);
        chk(irq, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_A_CONTROL), 32'hC0, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_IRQ_MASK), 32'h3, 0, 1'b0);
        acc(1'b1, ad(erp_pkg::ERP_IDX_IRQ_STATUS), 32'h1, 0, 1'b0);
        acc(1'b0, ad(erp_pkg::ERP_IDX_IRQ_STATUS), 0, 32'h0, 1'b0);
        @(negedge pclk);
        chk(irq, 1'b0);
        $display("test interrupt done");
        complete_run();
    end
endmodule // tb_erp_top
